// ==== tb/jtsp_link_rx_model.sv ====
// Purpose: Behavioural receiver that takes lane frames from the sample packer.
// Assumes: One clock; the receiver has no link mode of its own and takes all lanes in every mode.
// Notes: Ready may be withheld at random or held off completely to back up the packer.
`timescale 1ns/1ps
`default_nettype none
module jtsp_link_rx_model (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 lane_valid,
  output logic                      lane_ready,
  input  wire jtsp_pkg::jtsp_lanes_t lane_data,
  input  wire logic [6:0]           stall_pct,
  input  wire logic                 hold,
  output logic                      got,
  output var jtsp_pkg::jtsp_lanes_t got_data
);
  integer seed = 32'h57237887;

  // All lanes are captured, so that unused high lanes can be seen to stay at zero.
  always @(posedge clk) begin
    if (!resetn) begin
      lane_ready <= 1'b0;
      got        <= 1'b0;
      got_data   <= '0;
    end else begin
      got <= lane_valid && lane_ready;
      if (lane_valid && lane_ready) begin
        got_data <= lane_data;
      end
      lane_ready <= !hold && (($unsigned($random(seed)) % 100) >= stall_pct);
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_jtsp_sample_packer.sv ====
// Purpose: Self-checking bench for the sample packer in every link mode and part kind.
// Assumes: Expected lanes are rebuilt from the packing order of each mode.
// Notes: Frames are compared in order as the receiver model takes them.
`timescale 1ns/1ps
`default_nettype none
module tb_jtsp_sample_packer import jtsp_pkg::*; ;
  logic           CLK, RESETN, LINK_EN, SMP_VALID, SMP_READY, LANE_VALID, LANE_READY, MODE_ERROR;
  logic [3:0]     LINK_MODE_SELECT;
  jtsp_part_t     PART_KIND;
  jtsp_frame_t    SMP_DATA;
  jtsp_lanes_t    LANE_DATA, got_data;
  jtsp_link_cfg_t LINK_CFG;
  logic           got, hold;
  logic [6:0]     stall_pct;
  integer         seed = 32'h57237887;
  int             fails, samples_checked, seen, cur_m;
  jtsp_part_t     cur_p;
  jtsp_frame_t    exp_q[$];

  jtsp_sample_packer #(.FIFO_DEPTH(8)) dut_u (.CLK(CLK), .RESETN(RESETN), .LINK_MODE_SELECT(LINK_MODE_SELECT),
    .PART_KIND(PART_KIND), .LINK_EN(LINK_EN), .SMP_VALID(SMP_VALID), .SMP_READY(SMP_READY), .SMP_DATA(SMP_DATA),
    .LANE_VALID(LANE_VALID), .LANE_READY(LANE_READY), .LANE_DATA(LANE_DATA), .LINK_CFG(LINK_CFG),
    .MODE_ERROR(MODE_ERROR));
  jtsp_link_rx_model rx_u (.clk(CLK), .resetn(RESETN), .lane_valid(LANE_VALID), .lane_ready(LANE_READY),
    .lane_data(LANE_DATA), .stall_pct(stall_pct), .hold(hold), .got(got), .got_data(got_data));

  function automatic int nlanes(int m, jtsp_part_t p);
    int t[3];
    case (m)
      1, 6:       t = '{6, 3, 2};
      2, 3, 7, 8: t = '{4, 2, 1};
      4:          t = '{3, 2, 1};
      5:          t = '{2, 1, 1};
      9:          t = '{8, 4, 2};
      default:    t = '{0, 0, 0};
    endcase
    return t[int'(p)];
  endfunction

  function automatic int noct(int m);
    case (m)
      2, 7, 9: return 1;
      3:       return 5;
      8:       return 3;
      default: return 2;
    endcase
  endfunction

  function automatic jtsp_link_cfg_t exp_cfg(int m, jtsp_part_t p);
    jtsp_link_cfg_t c;
    c            = '0;
    c.supported  = 1'b1;
    c.lane_en    = 8'((1 << nlanes(m, p)) - 1);
    c.octets     = 3'(noct(m));
    c.enc_64b66b = (m >= 4 && m <= 8);
    return c;
  endfunction

  // Builds the MSB-first stream of padded words; absent channels still occupy their slots as zeros.
  function automatic jtsp_lanes_t exp_lanes(int m, jtsp_part_t p, jtsp_frame_t f);
    logic [319:0] s;
    logic [11:0]  w;
    jtsp_lanes_t  r;
    int           pos, ns, wb, nch, oc;
    s   = '0;
    r   = '0;
    pos = 0;
    oc  = noct(m);
    nch = (p == JTSP_QUAD) ? 4 : (p == JTSP_DUAL) ? 2 : 1;
    ns  = (m == 3) ? 4 : (m == 2 || m == 4 || m == 5 || m == 7) ? 1 : 2;
    wb  = (m == 3) ? 10 : (m == 1 || m == 4 || m == 6 || m == 8) ? 12 : 8;
    for (int c = 0; c < 4; c++) begin
      for (int n = 0; n < ns; n++) begin
        w = (wb == 12) ? {f.smp[c][n], 3'h0} : (wb == 10) ? {2'h0, f.smp[c][n], 1'h0} : {4'h0, f.smp[c][n][8:1]};
        for (int b = 0; b < wb; b++) begin
          s[319-pos-b] = (c < nch) ? w[wb-1-b] : 1'b0;
        end
        pos += wb;
      end
    end
    for (int k = 0; k < nlanes(m, p); k++) begin
      for (int b = 0; b < 8 * oc; b++) begin
        r.lane[k][39-b] = s[319-8*oc*k-b];
      end
    end
    return r;
  endfunction

  function automatic jtsp_frame_t rnd_frame();
    jtsp_frame_t f;
    for (int i = 0; i < 16; i++) begin
      f.smp[i/4][i%4] = 9'($random(seed));
    end
    return f;
  endfunction

  task automatic final_report();
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_val(logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_cfg(jtsp_link_cfg_t e, jtsp_link_cfg_t g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_lanes(jtsp_lanes_t e, jtsp_lanes_t g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  // Valid is left high on return, so back-to-back calls never assign it twice in one step.
  task automatic send(jtsp_frame_t f, bit keep);
    SMP_DATA  = f;
    SMP_VALID = 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge CLK);
      if (SMP_READY === 1'b1) begin
        tick(1);
        if (keep) exp_q.push_back(f);
        return;
      end
      tick(1);
    end
    fails++;
    final_report();
  endtask

  task automatic drain();
    for (int i = 0; i < 600; i++) begin
      if (exp_q.size() == 0) return;
      tick(1);
    end
    fails++;
    final_report();
  endtask

  task automatic run_cfg(int m, jtsp_part_t p, int n, logic [6:0] st);
    jtsp_frame_t f;
    int          s0;
    bit          ok;
    ok               = (m >= 1 && m <= 9);
    LINK_EN          = 1'b0;
    LINK_MODE_SELECT = 4'(m);
    PART_KIND        = p;
    cur_m            = m;
    cur_p            = p;
    stall_pct        = st;
    tick(3);
    if (ok) chk_cfg(exp_cfg(m, p), LINK_CFG);
    else chk_val(32'h0, 32'(LINK_CFG.lane_en));
    chk_val(32'(!ok), 32'(MODE_ERROR));
    LINK_EN = 1'b1;
    tick(1);
    LINK_MODE_SELECT = 4'((m % 9) + 1);
    tick(2);
    if (ok) chk_cfg(exp_cfg(m, p), LINK_CFG);
    s0 = seen;
    for (int i = 0; i < n; i++) begin
      f = (i == 0) ? '1 : (i == 1) ? {16{9'h155}} : rnd_frame();
      send(f, ok);
    end
    SMP_VALID = 1'b0;
    drain();
    if (!ok) begin
      tick(6);
      chk_val(32'h0, 32'(seen - s0));
    end
  endtask

  always @(posedge CLK) begin
    if (got) begin
      seen++;
      if (exp_q.size() == 0) begin
        fails++;
        $display("Error at %0t: unexpected frame %h", $time, got_data);
      end else begin
        chk_lanes(exp_lanes(cur_m, cur_p, exp_q.pop_front()), got_data);
      end
    end
  end

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  initial begin
    jtsp_frame_t f;
    int          acc;
    logic        r;
    RESETN           = 1'b0;
    LINK_EN          = 1'b0;
    SMP_VALID        = 1'b0;
    SMP_DATA         = '0;
    LINK_MODE_SELECT = 4'h1;
    PART_KIND        = JTSP_QUAD;
    hold             = 1'b0;
    stall_pct        = 7'h0;
    tick(12);
    chk_val(32'h0, 32'(LANE_VALID));
    RESETN = 1'b1;
    for (int m = 0; m <= 10; m++) begin
      for (int p = 0; p < 3; p++) begin
        run_cfg(m, jtsp_part_t'(p), 6, 7'((m * 13 + p * 11) % 60));
      end
    end
    // Back-pressure: the receiver stalls until the packer refuses further samples.
    run_cfg(2, JTSP_QUAD, 2, 7'h0);
    hold      = 1'b1;
    acc       = 0;
    SMP_VALID = 1'b1;
    for (int i = 0; i < 20; i++) begin
      f        = rnd_frame();
      SMP_DATA = f;
      @(negedge CLK);
      r = SMP_READY;
      tick(1);
      if (r !== 1'b1) break;
      exp_q.push_back(f);
      acc++;
    end
    SMP_VALID = 1'b0;
    // Eight words fill the FIFO and one more waits in the output register.
    chk_val(32'h9, 32'(acc));
    tick(3);
    chk_val(32'h0, 32'(SMP_READY));
    hold = 1'b0;
    drain();
    tick(4);
    final_report();
  end
endmodule
`default_nettype wire

// ==== verilog/jtsp_fifo.sv ====
// Purpose: Sample FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: Read data come from the store's output register, addressed one cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module jtsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [AW-1:0] wr_q;
  logic [AW-1:0] wr_d;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  jtsp_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk   (clk),
    .we    (push),
    .waddr (wr_q),
    .wdata (in_data),
    .raddr (rd_d),
    .rdata (out_data)
  );
endmodule
`default_nettype wire

// ==== verilog/jtsp_mem.sv ====
// Purpose: Small dual-port store for the sample FIFO.
// Assumes: One write and one read per cycle.
// Notes: A write to the address being read is forwarded so a fall-through FIFO sees it at once.
`timescale 1ns/1ps
`default_nettype none
module jtsp_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ==== verilog/jtsp_pkg.sv ====
// Purpose: Types shared by the sample packer, its receiver model and its bench.
// Assumes: jtsp_regs.svh is on the include path.
// Notes: Channel A is index 0 of every sample array.
`default_nettype none
package jtsp_pkg;
`include "jtsp_regs.svh"

  typedef enum logic [1:0] {JTSP_QUAD, JTSP_DUAL, JTSP_SINGLE} jtsp_part_t;

  typedef enum logic {JTSP_ST_IDLE, JTSP_ST_RUN} jtsp_state_t;

  typedef logic [`JTSP_SMP_BITS-1:0] jtsp_smp_t;

  typedef struct packed {
    jtsp_smp_t [`JTSP_NUM_CH-1:0][`JTSP_SMP_PER_CH-1:0] smp;
  } jtsp_frame_t;

  typedef struct packed {
    logic [`JTSP_NUM_LANES-1:0][`JTSP_LANE_BITS-1:0] lane;
  } jtsp_lanes_t;

  typedef struct packed {
    logic [`JTSP_NUM_LANES-1:0] lane_en;
    logic [2:0]                 octets;
    logic                       enc_64b66b;
    logic                       supported;
  } jtsp_link_cfg_t;

endpackage
`default_nettype wire

// ==== verilog/jtsp_regs.svh ====
// Purpose: Constants for the transport-layer sample packer.
// Assumes: Included by the package and by the packer; guarded against double inclusion.
// Notes: Lane tables hold three nibbles: quad, dual and single part lane counts.
`ifndef JTSP_REGS_SVH
`define JTSP_REGS_SVH

`define JTSP_MODE_W      4
`define JTSP_MODE_RST    4'h1

`define JTSP_M1          4'h1
`define JTSP_M2          4'h2
`define JTSP_M3          4'h3
`define JTSP_M4          4'h4
`define JTSP_M5          4'h5
`define JTSP_M6          4'h6
`define JTSP_M7          4'h7
`define JTSP_M8          4'h8
`define JTSP_M9          4'h9

`define JTSP_LANES_M1    12'h632
`define JTSP_LANES_M2    12'h421
`define JTSP_LANES_M3    12'h421
`define JTSP_LANES_M4    12'h321
`define JTSP_LANES_M5    12'h211
`define JTSP_LANES_M6    12'h632
`define JTSP_LANES_M7    12'h421
`define JTSP_LANES_M8    12'h421
`define JTSP_LANES_M9    12'h842

`define JTSP_OCT_M1      3'h2
`define JTSP_OCT_M2      3'h1
`define JTSP_OCT_M3      3'h5
`define JTSP_OCT_M4      3'h2
`define JTSP_OCT_M5      3'h2
`define JTSP_OCT_M6      3'h2
`define JTSP_OCT_M7      3'h1
`define JTSP_OCT_M8      3'h3
`define JTSP_OCT_M9      3'h1

`define JTSP_NUM_LANES   8
`define JTSP_LANE_BITS   40
`define JTSP_NUM_CH      4
`define JTSP_SMP_PER_CH  4
`define JTSP_SMP_BITS    9
`define JTSP_STREAM_BITS 160
`define JTSP_FIFO_DEPTH  8

`endif

// ==== verilog/jtsp_sample_packer.sv ====
// Purpose: Maps converter samples into lane frames for each link mode.
// Assumes: Inputs are synchronous to CLK; one input word holds one frame's samples.
// Notes: Lane data are left-justified in 40 bits, octet 0 in the top byte.
`timescale 1ns/1ps
`default_nettype none
`include "jtsp_regs.svh"
module jtsp_sample_packer #(
  parameter int FIFO_DEPTH = `JTSP_FIFO_DEPTH
) (
  input  wire logic                       CLK,
  input  wire logic                       RESETN,
  input  wire logic [`JTSP_MODE_W-1:0]    LINK_MODE_SELECT,
  input  wire jtsp_pkg::jtsp_part_t       PART_KIND,
  input  wire logic                       LINK_EN,
  input  wire logic                       SMP_VALID,
  output logic                            SMP_READY,
  input  wire jtsp_pkg::jtsp_frame_t      SMP_DATA,
  output logic                            LANE_VALID,
  input  wire logic                       LANE_READY,
  output var jtsp_pkg::jtsp_lanes_t       LANE_DATA,
  output var jtsp_pkg::jtsp_link_cfg_t    LINK_CFG,
  output logic                            MODE_ERROR
);
  import jtsp_pkg::*;

  jtsp_state_t             st_q;
  jtsp_state_t             st_d;
  logic [`JTSP_MODE_W-1:0] mode_q;
  logic [`JTSP_MODE_W-1:0] mode_d;
  jtsp_part_t              part_q;
  jtsp_part_t              part_d;
  jtsp_link_cfg_t          cfg_q;
  jtsp_link_cfg_t          cfg_d;
  logic                    valid_q;
  logic                    valid_d;
  jtsp_lanes_t             lanes_q;
  jtsp_lanes_t             lanes_d;

  logic                    fifo_v;
  logic                    pop;
  jtsp_frame_t             head;
  logic [11:0]             lane_tbl;
  logic [3:0]              nlanes;
  logic [`JTSP_STREAM_BITS-1:0] pk;
  logic [5:0]              lane_w;
  logic [`JTSP_LANE_BITS-1:0]   lane_mask;
  jtsp_lanes_t             packed_w;
  logic [`JTSP_NUM_CH-1:0] ch_on;
  jtsp_smp_t [`JTSP_NUM_CH-1:0][`JTSP_SMP_PER_CH-1:0] s;
  logic [`JTSP_NUM_LANES-1:0][`JTSP_STREAM_BITS-1:0] lane_sh;

  // Back-pressure: when the FIFO is full SMP_READY falls and the source stalls.
  jtsp_fifo #(
    .WIDTH ($bits(jtsp_frame_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .resetn    (RESETN),
    .in_valid  (SMP_VALID),
    .in_ready  (SMP_READY),
    .in_data   (SMP_DATA),
    .out_valid (fifo_v),
    .out_ready (pop),
    .out_data  (head)
  );

  // Link configuration follows the mode that will be held in the next cycle.
  always_comb begin
    lane_tbl            = 12'h000;
    cfg_d               = '0;
    cfg_d.supported     = 1'b1;
    case (mode_d)
      `JTSP_M1: begin
        lane_tbl     = `JTSP_LANES_M1;
        cfg_d.octets = `JTSP_OCT_M1;
      end
      `JTSP_M2: begin
        lane_tbl     = `JTSP_LANES_M2;
        cfg_d.octets = `JTSP_OCT_M2;
      end
      `JTSP_M3: begin
        lane_tbl     = `JTSP_LANES_M3;
        cfg_d.octets = `JTSP_OCT_M3;
      end
      `JTSP_M4: begin
        lane_tbl         = `JTSP_LANES_M4;
        cfg_d.octets     = `JTSP_OCT_M4;
        cfg_d.enc_64b66b = 1'b1;
      end
      `JTSP_M5: begin
        lane_tbl         = `JTSP_LANES_M5;
        cfg_d.octets     = `JTSP_OCT_M5;
        cfg_d.enc_64b66b = 1'b1;
      end
      `JTSP_M6: begin
        lane_tbl         = `JTSP_LANES_M6;
        cfg_d.octets     = `JTSP_OCT_M6;
        cfg_d.enc_64b66b = 1'b1;
      end
      `JTSP_M7: begin
        lane_tbl         = `JTSP_LANES_M7;
        cfg_d.octets     = `JTSP_OCT_M7;
        cfg_d.enc_64b66b = 1'b1;
      end
      `JTSP_M8: begin
        lane_tbl         = `JTSP_LANES_M8;
        cfg_d.octets     = `JTSP_OCT_M8;
        cfg_d.enc_64b66b = 1'b1;
      end
      `JTSP_M9: begin
        lane_tbl     = `JTSP_LANES_M9;
        cfg_d.octets = `JTSP_OCT_M9;
      end
      default: begin
        cfg_d.supported = 1'b0;
      end
    endcase
    case (part_d)
      JTSP_QUAD: nlanes = lane_tbl[11:8];
      JTSP_DUAL: nlanes = lane_tbl[7:4];
      default:   nlanes = lane_tbl[3:0];
    endcase
    // Only the lowest lanes are enabled; the rest stay powered down.
    cfg_d.lane_en = 8'(~(9'h1ff << nlanes));
  end

  // Channels missing on the part send zeros in their positions.
  for (genvar gc = 0; gc < `JTSP_NUM_CH; gc++) begin : g_ch
    assign ch_on[gc] = (gc == 0) || (part_q == JTSP_QUAD) || ((gc == 1) && (part_q == JTSP_DUAL));
    assign s[gc]     = ch_on[gc] ? head.smp[gc] : '0;
  end

  // Each mode becomes one MSB-first bit stream that the lanes slice in turn.
  always_comb begin
    pk = '0;
    case (mode_q)
      `JTSP_M1, `JTSP_M6, `JTSP_M8: begin
        pk = {s[0][0], 3'h0, s[0][1], 3'h0, s[1][0], 3'h0, s[1][1], 3'h0,
              s[2][0], 3'h0, s[2][1], 3'h0, s[3][0], 3'h0, s[3][1], 3'h0, 64'h0};
      end
      `JTSP_M4: begin
        pk = {s[0][0], 3'h0, s[1][0], 3'h0, s[2][0], 3'h0, s[3][0], 3'h0, 112'h0};
      end
      `JTSP_M2, `JTSP_M5, `JTSP_M7: begin
        pk = {s[0][0][8:1], s[1][0][8:1], s[2][0][8:1], s[3][0][8:1], 128'h0};
      end
      `JTSP_M3: begin
        pk = {s[0][0], 1'b0, s[0][1], 1'b0, s[0][2], 1'b0, s[0][3], 1'b0,
              s[1][0], 1'b0, s[1][1], 1'b0, s[1][2], 1'b0, s[1][3], 1'b0,
              s[2][0], 1'b0, s[2][1], 1'b0, s[2][2], 1'b0, s[2][3], 1'b0,
              s[3][0], 1'b0, s[3][1], 1'b0, s[3][2], 1'b0, s[3][3], 1'b0};
      end
      `JTSP_M9: begin
        pk = {s[0][0][8:1], s[0][1][8:1], s[1][0][8:1], s[1][1][8:1],
              s[2][0][8:1], s[2][1][8:1], s[3][0][8:1], s[3][1][8:1], 96'h0};
      end
      default: pk = '0;
    endcase
  end

  // The lane width in bits is always eight times the octets per frame.
  assign lane_w    = {cfg_q.octets, 3'h0};
  assign lane_mask = ~({`JTSP_LANE_BITS{1'b1}} >> lane_w);

  for (genvar gl = 0; gl < `JTSP_NUM_LANES; gl++) begin : g_lane
    assign lane_sh[gl] = pk << (9'(lane_w) * 9'(gl));
    assign packed_w.lane[gl] = cfg_q.lane_en[gl] ?
        (lane_sh[gl][`JTSP_STREAM_BITS-1 -: `JTSP_LANE_BITS] & lane_mask) : '0;
  end

  // The mode is sampled only while idle, so a running link never sees it change.
  always_comb begin
    st_d    = st_q;
    mode_d  = mode_q;
    part_d  = part_q;
    valid_d = valid_q;
    lanes_d = lanes_q;
    pop     = 1'b0;
    case (st_q)
      JTSP_ST_IDLE: begin
        mode_d  = LINK_MODE_SELECT;
        part_d  = PART_KIND;
        valid_d = 1'b0;
        lanes_d = '0;
        pop     = fifo_v;
        if (LINK_EN) begin
          st_d = JTSP_ST_RUN;
        end
      end
      JTSP_ST_RUN: begin
        if (valid_q && LANE_READY) begin
          valid_d = 1'b0;
        end
        if (fifo_v && (!valid_q || LANE_READY)) begin
          pop = 1'b1;
          if (cfg_q.supported) begin
            lanes_d = packed_w;
            valid_d = 1'b1;
          end
        end
        if (!LINK_EN) begin
          st_d    = JTSP_ST_IDLE;
          valid_d = 1'b0;
        end
      end
      default: st_d = JTSP_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q    <= JTSP_ST_IDLE;
      mode_q  <= `JTSP_MODE_RST;
      part_q  <= JTSP_QUAD;
      cfg_q   <= '0;
      valid_q <= 1'b0;
      lanes_q <= '0;
    end else begin
      st_q    <= st_d;
      mode_q  <= mode_d;
      part_q  <= part_d;
      cfg_q   <= cfg_d;
      valid_q <= valid_d;
      lanes_q <= lanes_d;
    end
  end

  assign LANE_VALID = valid_q;
  assign LANE_DATA  = lanes_q;
  assign LINK_CFG   = cfg_q;
  assign MODE_ERROR = !cfg_q.supported;

  logic       off_lane_nz;
  logic [8:0] head_a0;
  logic       took;
  assign head_a0 = s[0][0];
  assign took    = pop && (st_q == JTSP_ST_RUN) && cfg_q.supported && !(!LINK_EN);

  always_comb begin
    off_lane_nz = 1'b0;
    for (int i = 0; i < `JTSP_NUM_LANES; i++) begin
      off_lane_nz = off_lane_nz | (!cfg_q.lane_en[i] && (lanes_q.lane[i] != '0));
    end
  end

  lanes_off_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
    LANE_VALID |-> !off_lane_nz)
    else $error("A powered-down lane carries data.");

  mode_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_q == JTSP_ST_RUN && LINK_EN) |=> $stable(mode_q))
    else $error("Link mode changed while the link was running.");

  mode1_quad_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && mode_q == `JTSP_M1 && part_q == JTSP_QUAD) |->
      (cfg_q.lane_en == 8'h3f && cfg_q.octets == 3'h2 && !cfg_q.enc_64b66b))
    else $error("Mode 1 quad lane setup wrong.");

  mode6_single_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && mode_q == `JTSP_M6 && part_q == JTSP_SINGLE) |->
      (cfg_q.lane_en == 8'h03 && cfg_q.enc_64b66b && lanes_q.lane[1][31:24] == 8'h00))
    else $error("Mode 6 single lane setup or zero fill wrong.");

  single_b_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && mode_q == `JTSP_M5 && part_q == JTSP_SINGLE) |-> lanes_q.lane[0][31:24] == 8'h00)
    else $error("Channel B octet not zero on a single part.");

  a0_msb_first_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (took && mode_q == `JTSP_M2) |=> (lanes_q.lane[0][39:32] == $past(head_a0[8:1]) && cfg_q.octets == 3'h1))
    else $error("Mode 2 lane 0 octet does not hold the channel A sample.");

  mode3_tails_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && mode_q == `JTSP_M3) |->
      (lanes_q.lane[0][30] == 1'b0 && lanes_q.lane[0][20] == 1'b0 &&
       lanes_q.lane[0][10] == 1'b0 && lanes_q.lane[0][0] == 1'b0))
    else $error("Mode 3 tail bit not zero.");

  mode4_quad_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && mode_q == `JTSP_M4 && part_q == JTSP_QUAD) |->
      (cfg_q.lane_en == 8'h07 && cfg_q.enc_64b66b && lanes_q.lane[0][30:28] == 3'h0))
    else $error("Mode 4 quad packing wrong.");

  mode7_octet_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && mode_q == `JTSP_M7) |-> (cfg_q.octets == 3'h1 && cfg_q.enc_64b66b))
    else $error("Mode 7 frame size or encoding wrong.");

  mode8_pad_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (took && mode_q == `JTSP_M8) |=>
      (lanes_q.lane[0][39:28] == {$past(head_a0), 3'h0} && lanes_q.lane[0][18:16] == 3'h0))
    else $error("Mode 8 sample padding wrong.");

  mode9_dual_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && mode_q == `JTSP_M9 && part_q == JTSP_DUAL) |->
      (cfg_q.lane_en == 8'h0f && !cfg_q.enc_64b66b))
    else $error("Mode 9 dual lane setup wrong.");

  frame_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (LANE_VALID && !LANE_READY && LINK_EN) |=> (LANE_VALID && $stable(lanes_q)))
    else $error("Frame changed while the link layer stalled.");
endmodule
`default_nettype wire
